// File: rtl/dtc_timer.sv
// Dual cascadable 8-bit timer/counter with an AHB-Lite register slave.
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module dtc_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [1:0] event_input_pin,
  input wire logic lf_clk_in,
  output logic [1:0] divider_output_pin,
  output logic [1:0] match_interrupt,
  output logic irq
);

  typedef struct packed {
    logic [1:0] ev_s1;
    logic [1:0] ev_s2;
    logic [1:0] ev_s3;
    logic fs_s1;
    logic fs_s2;
    logic fs_s3;
    logic [dtc_pkg::FS_DIV_W-1:0] fs_cnt;
    logic [dtc_pkg::PRE_W-1:0] pre;
    dtc_pkg::dtc_ctrl_t [1:0] ctrl;
    logic [1:0][7:0] period;
    logic [1:0][7:0] count;
    logic [1:0] ff;
    logic [1:0] match;
    logic [1:0] status;
    logic [1:0] mask;
    dtc_pkg::dtc_power_t power;
    logic dp_act;
    logic dp_write;
    logic rd_ready;
    logic [dtc_pkg::ADDR_W-1:0] dp_addr;
    logic [31:0] rdata;
  } dtc_state_t;

  dtc_state_t s_reg;
  dtc_state_t s_next;

  logic fs_tick;
  logic [1:0] ev_fall;
  logic [1:0] tick;
  logic wr_en;

  // Picks the counting pulse of one counter from its clock select.
  function automatic logic dtc_src_tick(
    input logic [2:0] sel,
    input dtc_pkg::dtc_power_t pwr,
    input logic [dtc_pkg::PRE_W-1:0] pre,
    input logic fs_t,
    input logic ev_f
  );
    logic t;
    t = 1'b0;
    if (pwr.slow_power_mode) begin
      if (sel == dtc_pkg::CK_SLOW_TAP) begin
        t = fs_t;
      end else if (sel == dtc_pkg::CK_PIN) begin
        t = ev_f;
      end
    end else begin
      case (sel)
        dtc_pkg::CK_SLOW_TAP: begin
          t = pwr.prescaler_tap_select ? fs_t : (&pre[dtc_pkg::TAP_11-1:0]);
        end
        dtc_pkg::CK_DIV7: begin
          t = &pre[dtc_pkg::TAP_7-1:0];
        end
        dtc_pkg::CK_DIV5: begin
          t = &pre[dtc_pkg::TAP_5-1:0];
        end
        dtc_pkg::CK_DIV3: begin
          t = &pre[dtc_pkg::TAP_3-1:0];
        end
        dtc_pkg::CK_PIN: begin
          t = ev_f;
        end
        default: begin
          t = 1'b0;
        end
      endcase
    end
    return t;
  endfunction : dtc_src_tick

  // Edge detectors look only at the second and third synchroniser stages.
  assign fs_tick = s_reg.fs_s2 & ~s_reg.fs_s3 & (&s_reg.fs_cnt);
  assign ev_fall = ~s_reg.ev_s2 & s_reg.ev_s3;
  assign wr_en = s_reg.dp_act & s_reg.dp_write;

  always_comb begin
    s_next = s_reg;
    tick = 2'b00;
    s_next.ev_s1 = event_input_pin;
    s_next.ev_s2 = s_reg.ev_s1;
    s_next.ev_s3 = s_reg.ev_s2;
    s_next.fs_s1 = lf_clk_in;
    s_next.fs_s2 = s_reg.fs_s1;
    s_next.fs_s3 = s_reg.fs_s2;
    if (s_reg.fs_s2 & ~s_reg.fs_s3) begin
      s_next.fs_cnt = s_reg.fs_cnt + {{(dtc_pkg::FS_DIV_W-1){1'b0}}, 1'b1};
    end
    s_next.pre = s_reg.pre + {{(dtc_pkg::PRE_W-1){1'b0}}, 1'b1};

    for (int i = 0; i < 2; i++) begin
      if (i == 1 && s_reg.ctrl[1].mode_select_field[dtc_pkg::MODE_CASCADE_BIT]) begin
        tick[i] = s_reg.match[0];
      end else begin
        tick[i] = dtc_src_tick(s_reg.ctrl[i].clock_select_field, s_reg.power,
                               s_reg.pre, fs_tick, ev_fall[i]);
      end
      s_next.match[i] = 1'b0;
      if (!s_reg.ctrl[i].run_control) begin
        s_next.count[i] = 8'h00;
      end else if (tick[i]) begin
        // The live period register is compared, so a new value acts at once.
        if (s_reg.count[i] == s_reg.period[i]) begin
          s_next.count[i] = 8'h00;
          s_next.match[i] = 1'b1;
          if (s_reg.ctrl[i].mode_select_field == dtc_pkg::MODE_DIVIDER) begin
            s_next.ff[i] = ~s_reg.ff[i];
          end
        end else begin
          s_next.count[i] = s_reg.count[i] + 8'h01;
        end
      end
    end

    // Bus address phase is taken only while the bus is ready.
    if (hsel && htrans[dtc_pkg::HTRANS_ACTIVE_BIT] && hready) begin
      s_next.dp_act = 1'b1;
      s_next.dp_write = hwrite;
      s_next.dp_addr = haddr[dtc_pkg::ADDR_W-1:0];
      s_next.rd_ready = 1'b0;
    end else if (hready) begin
      s_next.dp_act = 1'b0;
      s_next.rd_ready = 1'b0;
    end else if (s_reg.dp_act && !s_reg.dp_write) begin
      s_next.rd_ready = 1'b1;
    end

    if (s_reg.dp_act && !s_reg.dp_write && !s_reg.rd_ready) begin
      case (s_reg.dp_addr)
        dtc_pkg::OFS_CTRL0: s_next.rdata = {24'h000000, s_reg.ctrl[0]};
        dtc_pkg::OFS_CTRL1: s_next.rdata = {24'h000000, s_reg.ctrl[1]};
        dtc_pkg::OFS_PERIOD0: s_next.rdata = {24'h000000, s_reg.period[0]};
        dtc_pkg::OFS_PERIOD1: s_next.rdata = {24'h000000, s_reg.period[1]};
        dtc_pkg::OFS_STATUS: s_next.rdata = {30'h0, s_reg.status};
        dtc_pkg::OFS_MASK: s_next.rdata = {30'h0, s_reg.mask};
        dtc_pkg::OFS_COUNT: s_next.rdata = {16'h0000, s_reg.count[1], s_reg.count[0]};
        dtc_pkg::OFS_POWER: s_next.rdata = {30'h0, s_reg.power};
        default: s_next.rdata = 32'h00000000;
      endcase
    end

    // Hardware set wins over a write-one clear in the same cycle.
    s_next.status = s_reg.status | s_next.match;
    if (wr_en) begin
      case (s_reg.dp_addr)
        dtc_pkg::OFS_CTRL0: begin
          s_next.ctrl[0] = hwdata[7:0];
          s_next.ff[0] = hwdata[7];
        end
        dtc_pkg::OFS_CTRL1: begin
          s_next.ctrl[1] = hwdata[7:0];
          s_next.ff[1] = hwdata[7];
        end
        dtc_pkg::OFS_PERIOD0: s_next.period[0] = hwdata[7:0];
        dtc_pkg::OFS_PERIOD1: s_next.period[1] = hwdata[7:0];
        dtc_pkg::OFS_STATUS: s_next.status = (s_reg.status & ~hwdata[1:0]) | s_next.match;
        dtc_pkg::OFS_MASK: s_next.mask = hwdata[1:0];
        dtc_pkg::OFS_POWER: s_next.power = hwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
      s_reg.ctrl <= {dtc_pkg::CTRL_RESET, dtc_pkg::CTRL_RESET};
      s_reg.period <= {dtc_pkg::PERIOD_RESET, dtc_pkg::PERIOD_RESET};
      s_reg.ff <= 2'b00;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout = ~(s_reg.dp_act & ~s_reg.dp_write & ~s_reg.rd_ready);
  assign hresp = 1'b0;
  assign hrdata = s_reg.rdata;
  assign divider_output_pin = ~s_reg.ff;
  assign match_interrupt = s_reg.match;
  assign irq = |(s_reg.status & s_reg.mask);

  default clocking dtc_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic ctrl_wr0;
  logic ctrl_wr1;
  assign ctrl_wr0 = wr_en && (s_reg.dp_addr == dtc_pkg::OFS_CTRL0);
  assign ctrl_wr1 = wr_en && (s_reg.dp_addr == dtc_pkg::OFS_CTRL1);

  a_match_clears_count: assert property (
    $rose(match_interrupt[0]) |-> s_reg.count[0] == 8'h00 && $past(s_reg.ctrl[0].run_control))
    else $error("Counter 0 did not clear on its match.");

  a_match_single_pulse: assert property (
    match_interrupt[1] |=> !match_interrupt[1])
    else $error("Match pulse on counter 1 lasted more than one cycle.");

  a_match_at_period: assert property (
    match_interrupt[0] |-> $past(s_reg.count[0]) == $past(s_reg.period[0]))
    else $error("Counter 0 matched against a stale period.");

  a_divider_toggles: assert property (
    (s_next.match[0] && s_reg.ctrl[0].mode_select_field == dtc_pkg::MODE_DIVIDER && !ctrl_wr0)
      |=> divider_output_pin[0] != $past(divider_output_pin[0]))
    else $error("Divider output did not toggle on match.");

  a_preset_drives_pin: assert property (
    ctrl_wr1 |=> divider_output_pin[1] == ~$past(hwdata[7]))
    else $error("Flip-flop preset did not reach the divider pin.");

  a_cascade_clocking: assert property (
    (s_reg.ctrl[1].mode_select_field[dtc_pkg::MODE_CASCADE_BIT] && s_reg.ctrl[1].run_control
      && !ctrl_wr1 && s_next.count[1] != s_reg.count[1]) |-> s_reg.match[0])
    else $error("Upper counter moved without a lower match.");

  a_event_edge_count: assert property (
    (s_reg.ctrl[0].clock_select_field == dtc_pkg::CK_PIN && s_reg.ctrl[0].run_control
      && !ctrl_wr0 && s_next.count[0] != s_reg.count[0]) |-> ev_fall[0])
    else $error("Event counter moved without a falling edge.");

  a_fast_tap_rate: assert property (
    (s_reg.ctrl[0].clock_select_field == dtc_pkg::CK_DIV3 && !s_reg.power.slow_power_mode
      && s_reg.ctrl[0].run_control && !ctrl_wr0 && s_next.count[0] != s_reg.count[0])
      |-> s_reg.pre[2:0] == 3'h7)
    else $error("Counter 0 stepped off the fc/8 tap.");

  a_reset_flipflop: assert property (@(posedge hclk) disable iff (1'b0)
    $rose(hresetn) |-> divider_output_pin == 2'b11)
    else $error("Output flip-flops not zero after reset.");

  // Checks that mirror those above, each for the other counter.
  a_match_clears_upper: assert property (
    $rose(match_interrupt[1]) |-> s_reg.count[1] == 8'h00)
    else $error("Counter 1 did not clear on its match.");

  a_match_pulse_lower: assert property (
    match_interrupt[0] |=> !match_interrupt[0])
    else $error("Match pulse on counter 0 lasted more than one cycle.");

  a_match_period_upper: assert property (
    match_interrupt[1] |-> $past(s_reg.count[1]) == $past(s_reg.period[1]))
    else $error("Counter 1 matched against a stale period.");

  a_divider_toggles_upper: assert property (
    (s_next.match[1] && s_reg.ctrl[1].mode_select_field == dtc_pkg::MODE_DIVIDER && !ctrl_wr1)
      |=> divider_output_pin[1] != $past(divider_output_pin[1]))
    else $error("Divider output 1 did not toggle on match.");

  a_preset_drives_lower: assert property (
    ctrl_wr0 |=> divider_output_pin[0] == ~$past(hwdata[7]))
    else $error("Flip-flop preset did not reach divider pin 0.");

  // Outside divider mode the pin moves only on a preset write.
  a_timer_holds_pin: assert property (
    (s_reg.ctrl[0].mode_select_field != dtc_pkg::MODE_DIVIDER && !ctrl_wr0)
      |=> $stable(divider_output_pin[0]))
    else $error("Divider pin 0 moved outside divider mode.");

  a_stop_clears_count: assert property (
    !s_reg.ctrl[0].run_control |=> s_reg.count[0] == 8'h00)
    else $error("Stopped counter 0 kept a nonzero count.");

  a_status_on_match: assert property (
    match_interrupt[0] |-> s_reg.status[0])
    else $error("Status bit 0 not set with its match pulse.");

  a_count_steps_lower: assert property (
    (s_reg.ctrl[0].run_control && !ctrl_wr0 && tick[0] && s_reg.count[0] != s_reg.period[0])
      |=> s_reg.count[0] == $past(s_reg.count[0]) + 8'h01)
    else $error("Counter 0 did not step by one on its tick.");

  a_count_steps_upper: assert property (
    (s_reg.ctrl[1].run_control && !ctrl_wr1 && tick[1] && s_reg.count[1] != s_reg.period[1])
      |=> s_reg.count[1] == $past(s_reg.count[1]) + 8'h01)
    else $error("Counter 1 did not step by one on its tick.");

  // In slow mode the fast taps are not available and must not clock the counter.
  a_slow_fast_blocked: assert property (
    (s_reg.power.slow_power_mode && s_reg.ctrl[0].clock_select_field == dtc_pkg::CK_DIV3
      && s_reg.ctrl[0].run_control && !ctrl_wr0) |=> $stable(s_reg.count[0]))
    else $error("Counter 0 counted on a fast tap in slow mode.");

  a_slow_tap_rate: assert property (
    (s_reg.power.slow_power_mode && s_reg.ctrl[0].clock_select_field == dtc_pkg::CK_SLOW_TAP
      && s_reg.ctrl[0].run_control && !ctrl_wr0 && s_next.count[0] != s_reg.count[0])
      |-> fs_tick)
    else $error("Counter 0 stepped off the fs/8 tap in slow mode.");

  a_cascade_follows_lower: assert property (
    (s_reg.ctrl[1].mode_select_field[dtc_pkg::MODE_CASCADE_BIT] && s_reg.ctrl[1].run_control
      && !ctrl_wr1 && s_reg.match[0]) |-> s_next.count[1] != s_reg.count[1])
    else $error("Upper counter ignored a lower match in cascade.");

  a_fast_tap_upper: assert property (
    (s_reg.ctrl[1].clock_select_field == dtc_pkg::CK_DIV3 && !s_reg.power.slow_power_mode
      && !s_reg.ctrl[1].mode_select_field[dtc_pkg::MODE_CASCADE_BIT]
      && s_reg.ctrl[1].run_control && !ctrl_wr1 && s_next.count[1] != s_reg.count[1])
      |-> s_reg.pre[2:0] == 3'h7)
    else $error("Counter 1 stepped off the fc/8 tap.");

  c_timer_match: cover property (match_interrupt[0]);
  c_cascade_match: cover property (
    s_reg.ctrl[1].mode_select_field[dtc_pkg::MODE_CASCADE_BIT] && match_interrupt[1]);
  c_read_wait: cover property (!hreadyout ##1 hreadyout);
  c_irq_raised: cover property ($rose(irq));
  c_slow_match: cover property (s_reg.power.slow_power_mode && match_interrupt[0]);

endmodule : dtc_timer

// File: inc/dtc_pkg.sv
// Constants and types of the dual 8-bit timer/counter block.
// Contract
// - Timer mode counts, matches, interrupts, clears, continues.
// - Period compare written takes effect immediately.
// - Clock select fc taps, fs tap; slow uses fs/8.
// - Event mode counts falling edges of event pin.
// - Divider mode toggles flip-flop on each match.
// - Divider pin shows inverse flip-flop; software presets it.
// - Output flip-flops reset to zero.
// - Upper counter in 16-bit mode clocks on lower match.
package dtc_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_CTRL0 = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_PERIOD0 = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_PERIOD1 = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_MASK = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_POWER = 5'h1c;

  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_DIVIDER = 3'h1;
  localparam int unsigned MODE_CASCADE_BIT = 2;

  localparam logic [2:0] CK_SLOW_TAP = 3'h0;
  localparam logic [2:0] CK_DIV7 = 3'h1;
  localparam logic [2:0] CK_DIV5 = 3'h2;
  localparam logic [2:0] CK_DIV3 = 3'h3;
  localparam logic [2:0] CK_PIN = 3'h7;

  localparam int unsigned PRE_W = 11;
  localparam int unsigned TAP_11 = 11;
  localparam int unsigned TAP_7 = 7;
  localparam int unsigned TAP_5 = 5;
  localparam int unsigned TAP_3 = 3;
  localparam int unsigned FS_DIV_W = 3;

  localparam int unsigned HTRANS_ACTIVE_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hff;

  // Bit 7 preset, bits 6:4 clock select, bits 3:1 mode, bit 0 run.
  typedef struct packed {
    logic output_flipflop_preset;
    logic [2:0] clock_select_field;
    logic [2:0] mode_select_field;
    logic run_control;
  } dtc_ctrl_t;

  typedef struct packed {
    logic prescaler_tap_select;
    logic slow_power_mode;
  } dtc_power_t;

endpackage : dtc_pkg

// File: test/dtc_event_src.sv
// Model of the external event source that feeds the counter's event pin.
`timescale 1ns/1ps
module dtc_event_src (
  input wire logic hclk,
  input wire logic fire,
  output logic event_input_pin = 1'b1
);
  logic [2:0] ph = 3'h0;

  // Each level lasts three clocks, giving one falling edge per six clocks of fire.
  always @(posedge hclk) begin
    if (!fire) begin
      ph <= 3'h0;
      event_input_pin <= 1'b1;
    end else begin
      ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      event_input_pin <= (ph > 3'h2);
    end
  end
endmodule : dtc_event_src

// File: test/dual_8bit_timer_counter_test.sv
// Self-checking testbench of the dual timer/counter with its bus tasks and scenarios.
`timescale 1ns/1ps
module dual_8bit_timer_counter_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic lf_clk_in = 1'b0;
  logic fire = 1'b0;
  logic ev0, hreadyout, hresp, irq, s, p;
  logic [31:0] hrdata, rd;
  logic [1:0] divider_output_pin, match_interrupt;
  int fail_count = 0;
  int check_count = 0;

  always #10 hclk = ~hclk;
  always #1530 lf_clk_in = ~lf_clk_in;

  dtc_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .event_input_pin({1'b1, ev0}), .lf_clk_in(lf_clk_in),
    .divider_output_pin(divider_output_pin), .match_interrupt(match_interrupt), .irq(irq));
  dtc_event_src SRC (.hclk(hclk), .fire(fire), .event_input_pin(ev0));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {27'h0, a};
    hwrite <= w;
    // The address phase stands until hready is seen high at a rising edge.
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    rd = hrdata;
    @(negedge hclk);
  endtask : ahb

  // Slow power mode: only the fs/8 tap counts, the fast taps stand still.
  task automatic test_slow();
    ahb(1, dtc_pkg::OFS_POWER, 1);
    ahb(1, dtc_pkg::OFS_PERIOD0, 1);
    ahb(1, dtc_pkg::OFS_CTRL0, 32'h31);
    repeat (40) @(negedge hclk);
    ahb(0, dtc_pkg::OFS_COUNT, 0);
    chk(rd[7:0], 0);
    ahb(1, dtc_pkg::OFS_CTRL0, 0);
    ahb(1, dtc_pkg::OFS_CTRL0, 32'h01);
    s = 1'b0;
    for (int n = 0; n < 3000 && !s; n++) begin
      @(negedge hclk);
      s = match_interrupt[0];
    end
    chk(s, 1);
    ahb(1, dtc_pkg::OFS_CTRL0, 0);
    ahb(1, dtc_pkg::OFS_POWER, 0);
  endtask : test_slow

  // Waits for one match pulse of counter i and checks that it lasts one clock.
  task automatic wait_match(input int i);
    s = 1'b0;
    for (int n = 0; n < 100 && !s; n++) begin
      @(negedge hclk);
      s = match_interrupt[i];
      p = divider_output_pin[i];
    end
    @(negedge hclk);
    chk(match_interrupt[i], 0);
  endtask : wait_match

  task automatic test_timer();
    chk(divider_output_pin, 2'b11);
    ahb(0, dtc_pkg::OFS_PERIOD0, 0);
    chk(rd, {24'h0, dtc_pkg::PERIOD_RESET});
    ahb(1, dtc_pkg::OFS_PERIOD0, 1);
    ahb(1, dtc_pkg::OFS_CTRL0, 32'h31);
    wait_match(0);
    chk(s, 1);
    chk(irq, 0);
    ahb(1, dtc_pkg::OFS_CTRL0, 0);
    ahb(0, dtc_pkg::OFS_STATUS, 0);
    chk(rd[0], 1);
    ahb(1, dtc_pkg::OFS_MASK, 1);
    chk(irq, 1);
    ahb(1, dtc_pkg::OFS_STATUS, 1);
    chk(irq, 0);
  endtask : test_timer

  task automatic test_event();
    ahb(1, dtc_pkg::OFS_PERIOD0, 2);
    ahb(1, dtc_pkg::OFS_CTRL0, 32'h71);
    @(posedge hclk);
    fire <= 1'b1;
    repeat (6) @(posedge hclk);
    fire <= 1'b0;
    repeat (8) @(negedge hclk);
    ahb(0, dtc_pkg::OFS_COUNT, 0);
    chk(rd[7:0], 1);
    @(posedge hclk);
    fire <= 1'b1;
    wait_match(0);
    chk(s, 1);
    @(posedge hclk);
    fire <= 1'b0;
    ahb(1, dtc_pkg::OFS_CTRL0, 0);
  endtask : test_event

  task automatic test_divider();
    ahb(1, dtc_pkg::OFS_PERIOD1, 1);
    ahb(1, dtc_pkg::OFS_CTRL1, 32'h33);
    wait_match(1);
    chk(p, 0);
    wait_match(1);
    chk(p, 1);
    ahb(1, dtc_pkg::OFS_CTRL1, 32'h80);
    chk(divider_output_pin[1], 0);
    ahb(1, dtc_pkg::OFS_CTRL1, 0);
    chk(divider_output_pin[1], 1);
  endtask : test_divider

  task automatic test_cascade();
    ahb(1, dtc_pkg::OFS_PERIOD0, 1);
    ahb(1, dtc_pkg::OFS_CTRL1, 32'h09);
    ahb(1, dtc_pkg::OFS_CTRL0, 32'h31);
    wait_match(0);
    ahb(0, dtc_pkg::OFS_COUNT, 0);
    chk(rd[15:8], 1);
    wait_match(1);
    chk(s, 1);
  endtask : test_cascade

  task automatic results();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    test_timer();
    test_event();
    test_divider();
    test_slow();
    test_cascade();
    results();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    results();
  end
endmodule : dual_8bit_timer_counter_test
